// ---- rtl/counting_channel.sv ----
// Counting channel end: drives select lines and shift clock, gathers words
`timescale 1ns/1ps
`default_nettype none
module counting_channel #(
  parameter int ADDR_SETTLE_CYC = enc_mux_pkg::ADDR_SETTLE_CYC
) (
  input wire logic I_CLK, // Core clock
  input wire logic I_RST_N, // Synchronous reset, active low
  enc_link_if.channel link, // Serial link toward the bases
  input wire logic I_START, // Request one read
  input wire logic [enc_mux_pkg::ADDR_W-1:0] I_ADDR, // Encoder address
  input wire logic I_DRIVE_ADDR, // 1 = drive select lines
  input wire logic [enc_mux_pkg::RATE_SEL_W-1:0] I_RATE_SEL, // Rate index
  output logic O_BUSY, // Read in progress
  output logic O_WORD_VALID, // One-cycle pulse with a new word
  output logic [enc_mux_pkg::WORD_W-1:0] O_WORD, // Last word read
  output logic O_SUPPLY_FAULT // Filtered supply fault from the base
);

  typedef struct packed {
    enc_mux_pkg::ch_state_t state;
    enc_mux_pkg::half_t half_len;
    enc_mux_pkg::half_t half_cnt;
    logic [enc_mux_pkg::SETTLE_W-1:0] settle_cnt;
    logic [enc_mux_pkg::BIT_CNT_W-1:0] bit_cnt;
    logic clk_out;
    logic [enc_mux_pkg::ADDR_W-1:0] sel;
    logic sel_oe;
    logic [2:0] data_sync;
    logic data_f;
    logic [2:0] fault_sync;
    logic fault_f;
    logic [enc_mux_pkg::WORD_W-1:0] shift;
    logic [enc_mux_pkg::WORD_W-1:0] word;
    logic valid;
  } ch_state_st_t;

  ch_state_st_t st;
  ch_state_st_t next_st;
  logic half_done;

  localparam logic [enc_mux_pkg::SETTLE_W-1:0] SETTLE_LAST =
    enc_mux_pkg::SETTLE_W'(ADDR_SETTLE_CYC - 1);
  localparam logic [enc_mux_pkg::BIT_CNT_W-1:0] LAST_BIT =
    enc_mux_pkg::BIT_CNT_W'(enc_mux_pkg::WORD_W - 1);
  localparam logic [enc_mux_pkg::BIT_CNT_W-1:0] GAP_LAST =
    enc_mux_pkg::BIT_CNT_W'(enc_mux_pkg::GAP_HALVES - 1);

  always_comb begin
    next_st = st;
    next_st.valid = 1'b0;

    next_st.data_sync = {st.data_sync[1:0], link.data};
    if (st.data_sync[1] == st.data_sync[2]) begin
      next_st.data_f = st.data_sync[2];
    end
    next_st.fault_sync = {st.fault_sync[1:0], link.supply_fault_return};
    if (st.fault_sync[1] == st.fault_sync[2]) begin
      next_st.fault_f = st.fault_sync[2];
    end

    half_done = (st.half_cnt == st.half_len - 10'h1);
    next_st.half_cnt = half_done ? '0 : st.half_cnt + 10'h1;

    unique case (st.state)
      enc_mux_pkg::CH_IDLE: begin
        next_st.half_cnt = '0;
        if (I_START) begin
          // Leaving lines undriven suits a lone base at address 00
          next_st.sel = I_ADDR;
          next_st.sel_oe = I_DRIVE_ADDR;
          // Rate follows link length; unused indices fall back to default
          if (I_RATE_SEL < enc_mux_pkg::RATE_SEL_W'(enc_mux_pkg::NUM_RATES))
          begin
            next_st.half_len = enc_mux_pkg::half_count(int'(I_RATE_SEL));
          end else begin
            next_st.half_len =
              enc_mux_pkg::half_count(enc_mux_pkg::RATE_DEFAULT);
          end
          next_st.settle_cnt = '0;
          next_st.state = enc_mux_pkg::CH_SETTLE;
        end
      end
      enc_mux_pkg::CH_SETTLE: begin
        next_st.half_cnt = '0;
        next_st.settle_cnt = st.settle_cnt + 16'h1;
        if (st.settle_cnt == SETTLE_LAST) begin
          next_st.clk_out = 1'b0;
          next_st.bit_cnt = '0;
          next_st.state = enc_mux_pkg::CH_LOW;
        end
      end
      enc_mux_pkg::CH_LOW: begin
        if (half_done) begin
          next_st.clk_out = 1'b1;
          next_st.state = enc_mux_pkg::CH_HIGH;
        end
      end
      enc_mux_pkg::CH_HIGH: begin
        // Sample late in the high half to cover both synchroniser delays
        if (half_done) begin
          next_st.shift = {st.shift[enc_mux_pkg::WORD_W-2:0], st.data_f};
          next_st.bit_cnt = st.bit_cnt + 5'h1;
          if (st.bit_cnt == LAST_BIT) begin
            next_st.word = {st.shift[enc_mux_pkg::WORD_W-2:0], st.data_f};
            next_st.valid = 1'b1;
            next_st.bit_cnt = '0;
            next_st.state = enc_mux_pkg::CH_GAP;
          end else begin
            next_st.clk_out = 1'b0;
            next_st.state = enc_mux_pkg::CH_LOW;
          end
        end
      end
      enc_mux_pkg::CH_GAP: begin
        if (half_done) begin
          next_st.bit_cnt = st.bit_cnt + 5'h1;
          if (st.bit_cnt == GAP_LAST) begin
            next_st.state = enc_mux_pkg::CH_IDLE;
          end
        end
      end
      default: begin
        next_st.clk_out = enc_mux_pkg::CLK_IDLE_LEVEL;
        next_st.state = enc_mux_pkg::CH_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      st <= '0;
      st.state <= enc_mux_pkg::CH_IDLE;
      st.half_len <= enc_mux_pkg::half_count(enc_mux_pkg::RATE_DEFAULT);
      st.clk_out <= enc_mux_pkg::CLK_IDLE_LEVEL;
      st.sel <= enc_mux_pkg::ADDR_RESET;
      st.data_sync <= {3{enc_mux_pkg::DATA_IDLE_LEVEL}};
      st.data_f <= enc_mux_pkg::DATA_IDLE_LEVEL;
    end else begin
      st <= next_st;
    end
  end

  assign link.serial_shift_clock = st.clk_out;
  assign link.sel_lo_drv = st.sel[0];
  assign link.sel_hi_drv = st.sel[1];
  assign link.sel_oe = st.sel_oe;
  assign O_BUSY = (st.state != enc_mux_pkg::CH_IDLE);
  assign O_WORD_VALID = st.valid;
  assign O_WORD = st.word;
  assign O_SUPPLY_FAULT = st.fault_f;

endmodule
`default_nettype wire

// ---- shared/enc_mux_pkg.sv ----
// Shared constants and types for the encoder multiplexing base and its channel
package enc_mux_pkg;

  // Parallel word and serial framing
  localparam int WORD_W = 24;
  localparam int BIT_CNT_W = 5;
  localparam int ADDR_W = 2;

  // Core clock
  localparam int CLK_HZ = 250_000_000;

  // Serial shift clock settings, fastest first, by link length
  localparam int NUM_RATES = 6;
  localparam int RATE_SEL_W = 3;
  localparam int RATE_DEFAULT = 4;
  localparam int RATE_HZ [NUM_RATES] = '{
    1_000_000, 750_000, 500_000, 375_000, 200_000, 150_000
  };
  localparam int HALF_W = 10;
  typedef logic [HALF_W-1:0] half_t;

  // Half period in core cycles, rounded up so the rate is never exceeded
  function automatic half_t half_count(input int idx);
    half_count = half_t'((CLK_HZ / 2) / RATE_HZ[idx] + ((CLK_HZ / 2) %
                 RATE_HZ[idx] != 0));
  endfunction

  // Idle gap between frames, in half periods of the shift clock
  localparam int GAP_HALVES = 4;

  // Select inputs answer slowly; wait for them before a frame
  localparam int ADDR_SETTLE_US = 50;
  localparam int ADDR_SETTLE_CYC = ADDR_SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int SETTLE_W = 16;

  // Encoder supply monitor
  localparam int SENSE_W = 12;
  localparam int PROD_W = 20;
  localparam int FAULT_DROP_PCT = 15;
  localparam int PCT_FULL = 100;

  // Values after reset
  localparam logic CLK_IDLE_LEVEL = 1'b1;
  localparam logic DATA_IDLE_LEVEL = 1'b1;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 2'h0;

  // States, Gray coded along the usual path except CH_GAP to CH_IDLE, which flips two bits
  typedef enum logic [0:0] {
    DEV_IDLE = 1'h0,
    DEV_SHIFT = 1'h1
  } dev_state_t;

  typedef enum logic [2:0] {
    CH_IDLE = 3'h0,
    CH_SETTLE = 3'h1,
    CH_LOW = 3'h3,
    CH_HIGH = 3'h2,
    CH_GAP = 3'h6
  } ch_state_t;

endpackage

// ---- shared/enc_link_if.sv ----
// Serial link and select lines between a counting channel and its base
`timescale 1ns/1ps
`default_nettype none
interface enc_link_if;
  logic serial_shift_clock;
  logic sel_lo_drv;
  logic sel_hi_drv;
  logic sel_oe;
  logic enc_select_lo;
  logic enc_select_hi;
  logic data_out;
  logic data_oe;
  logic data;
  logic supply_fault_return;

  // Undriven select lines sit at zero, so a lone base reads address 00
  assign enc_select_lo = sel_oe ? sel_lo_drv : 1'b0;
  assign enc_select_hi = sel_oe ? sel_hi_drv : 1'b0;
  // Released data line idles high
  assign data = data_oe ? data_out : enc_mux_pkg::DATA_IDLE_LEVEL;

  modport base (
    input serial_shift_clock,
    input enc_select_lo,
    input enc_select_hi,
    output data_out,
    output data_oe,
    output supply_fault_return
  );

  modport channel (
    output serial_shift_clock,
    output sel_lo_drv,
    output sel_hi_drv,
    output sel_oe,
    input data,
    input supply_fault_return
  );
endinterface
`default_nettype wire

// ---- rtl/encoder_base.sv ----
// Encoder multiplexing base: selects one encoder and shifts its word out
`timescale 1ns/1ps
`default_nettype none
module encoder_base (
  input wire logic I_CLK, // Core clock
  input wire logic I_RST_N, // Synchronous reset, active low
  enc_link_if.base link, // Serial link toward the channel
  input wire logic [enc_mux_pkg::WORD_W-1:0] I_PARALLEL_WORD_INPUTS, // Pins
  input wire logic I_TWO_ENCODERS, // Count switch: 1 = two encoders
  input wire logic [enc_mux_pkg::ADDR_W-1:0] I_FIRST_ADDR, // First address
  input wire logic I_NEG_LOGIC, // Encoders have negative logic outputs
  input wire logic I_INHIBIT_ACT_HIGH, // Inhibit command active at 1
  input wire logic [enc_mux_pkg::SENSE_W-1:0] I_SUPPLY_NOMINAL, // Nominal
  input wire logic [enc_mux_pkg::SENSE_W-1:0] I_SUPPLY_SENSE, // Measured
  output logic O_INHIBIT_ENCODER_A, // Inhibit command, encoder 0
  output logic O_INHIBIT_ENCODER_B, // Inhibit command, encoder 1
  output logic O_BUSY // Frame in progress
);

  typedef struct packed {
    logic [2:0] clk_sync;
    logic clk_level;
    logic [2:0][enc_mux_pkg::ADDR_W-1:0] sel_sync;
    logic [enc_mux_pkg::ADDR_W-1:0] addr;
    logic [2:0][enc_mux_pkg::WORD_W-1:0] word_sync;
    logic [enc_mux_pkg::WORD_W-1:0] word;
    logic [enc_mux_pkg::WORD_W-1:0] shift;
    logic [enc_mux_pkg::BIT_CNT_W-1:0] bit_cnt;
    enc_mux_pkg::dev_state_t state;
    enc_mux_pkg::half_t span;
    logic tail;
    logic data_oe;
    logic inh_a;
    logic inh_b;
    logic fault;
  } base_state_t;

  base_state_t st;
  base_state_t next_st;

  logic clk_stable;
  logic next_clk;
  logic fall;
  logic rise;
  logic [enc_mux_pkg::ADDR_W-1:0] sel_stable;
  logic [enc_mux_pkg::WORD_W-1:0] word_stable;
  logic [enc_mux_pkg::WORD_W-1:0] read_word;
  logic mine_a;
  logic mine_b;
  logic selected;
  logic [enc_mux_pkg::PROD_W-1:0] sense_scaled;
  logic [enc_mux_pkg::PROD_W-1:0] limit_scaled;
  logic low_supply;

  localparam logic [enc_mux_pkg::BIT_CNT_W-1:0] LAST_BIT =
    enc_mux_pkg::BIT_CNT_W'(enc_mux_pkg::WORD_W);
  localparam logic [enc_mux_pkg::ADDR_W-1:0] TOP_ADDR = '1;
  // Span counter saturates; it counts whole bit periods, but only the last low half is ever used
  localparam enc_mux_pkg::half_t SPAN_TOP = '1;

  always_comb begin
    next_st = st;

    // Pin inputs: three stages, a change counts when stages two and three agree
    next_st.clk_sync = {st.clk_sync[1:0], link.serial_shift_clock};
    next_st.sel_sync[0] = {link.enc_select_hi, link.enc_select_lo};
    next_st.sel_sync[1] = st.sel_sync[0];
    next_st.sel_sync[2] = st.sel_sync[1];
    next_st.word_sync[0] = I_PARALLEL_WORD_INPUTS;
    next_st.word_sync[1] = st.word_sync[0];
    next_st.word_sync[2] = st.word_sync[1];

    clk_stable = ~(st.clk_sync[1] ^ st.clk_sync[2]);
    next_clk = clk_stable ? st.clk_sync[2] : st.clk_level;
    next_st.clk_level = next_clk;
    fall = st.clk_level & ~next_clk;
    rise = ~st.clk_level & next_clk;

    sel_stable = ~(st.sel_sync[1] ^ st.sel_sync[2]);
    next_st.addr = (sel_stable & st.sel_sync[2]) | (~sel_stable & st.addr);

    // Bitwise filter so a slow bit does not hold back the others
    word_stable = ~(st.word_sync[1] ^ st.word_sync[2]);
    next_st.word = (word_stable & st.word_sync[2]) | (~word_stable & st.word);

    // Input 0 is the lowest bit; unused inputs are grounded in positive
    // logic and float high in negative logic, so both read as 0
    read_word = I_NEG_LOGIC ? ~st.word : st.word;

    // Each base owns its first address, and the next one when full, so a
    // chain fills the four addresses in order; no owner means no reading
    mine_a = (st.addr == I_FIRST_ADDR);
    mine_b = I_TWO_ENCODERS && (I_FIRST_ADDR != TOP_ADDR) &&
             (st.addr == I_FIRST_ADDR + 2'h1);
    selected = mine_a | mine_b;

    // Only the addressed encoder drives the shared inputs
    next_st.inh_a = ~mine_a;
    next_st.inh_b = ~mine_b;

    // Supply monitor only meaningful with a single encoder on the base
    sense_scaled = enc_mux_pkg::PROD_W'(I_SUPPLY_SENSE) *
                   enc_mux_pkg::PROD_W'(enc_mux_pkg::PCT_FULL);
    limit_scaled = enc_mux_pkg::PROD_W'(I_SUPPLY_NOMINAL) *
                   enc_mux_pkg::PROD_W'(enc_mux_pkg::PCT_FULL -
                                         enc_mux_pkg::FAULT_DROP_PCT);
    low_supply = sense_scaled < limit_scaled;
    next_st.fault = ~I_TWO_ENCODERS & low_supply;

    // Frame: each detected fall presents the next bit. The channel samples
    // late in the high half, after the last edge the base can see, so
    // the length of the last low half is measured and bit 0 is held that
    // long again past the last rise. Releasing at the rise itself would
    // let the idle-high line be read as bit 0.
    // A new fall during the hold ends it at once, but that fall does
    // not start the next frame.
    unique case (st.state)
      enc_mux_pkg::DEV_IDLE: begin
        next_st.data_oe = 1'b0;
        if (fall && selected) begin
          // Snapshot taken once; later input motion cannot tear the word
          next_st.shift = read_word;
          next_st.bit_cnt = enc_mux_pkg::BIT_CNT_W'(1);
          next_st.span = '0;
          next_st.tail = 1'b0;
          next_st.data_oe = 1'b1;
          next_st.state = enc_mux_pkg::DEV_SHIFT;
        end
      end
      enc_mux_pkg::DEV_SHIFT: begin
        if (st.tail) begin
          // Bit 0 must outlast the channel's late sample in the high half
          if (st.span == '0 || fall) begin
            next_st.data_oe = 1'b0;
            next_st.tail = 1'b0;
            next_st.state = enc_mux_pkg::DEV_IDLE;
          end else begin
            next_st.span = st.span - 10'h1;
          end
        end else if (rise && st.bit_cnt == LAST_BIT) begin
          // Span now holds one low half; hold bit 0 as long again
          next_st.tail = 1'b1;
        end else if (fall) begin
          next_st.shift = {st.shift[enc_mux_pkg::WORD_W-2:0], 1'b0};
          next_st.bit_cnt = st.bit_cnt + 5'h1;
          next_st.span = '0;
        end else if (st.span != SPAN_TOP) begin
          next_st.span = st.span + 10'h1;
        end
      end
    endcase
  end

  // Both inhibits active during reset; the first cycle after it decodes the
  // reset address 00, so encoder A of a base at first address 00 drives at once
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      st <= '0;
      st.clk_sync <= {3{enc_mux_pkg::CLK_IDLE_LEVEL}};
      st.clk_level <= enc_mux_pkg::CLK_IDLE_LEVEL;
      st.addr <= enc_mux_pkg::ADDR_RESET;
      st.inh_a <= 1'b1;
      st.inh_b <= 1'b1;
      st.state <= enc_mux_pkg::DEV_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // MSB leaves first; the line is released outside a frame
  assign link.data_out = st.shift[enc_mux_pkg::WORD_W-1];
  assign link.data_oe = st.data_oe;
  assign link.supply_fault_return = st.fault;

  // Command polarity follows the inhibit switch
  assign O_INHIBIT_ENCODER_A = I_INHIBIT_ACT_HIGH ? st.inh_a : ~st.inh_a;
  assign O_INHIBIT_ENCODER_B = I_INHIBIT_ACT_HIGH ? st.inh_b : ~st.inh_b;
  assign O_BUSY = (st.state == enc_mux_pkg::DEV_SHIFT);

endmodule
`default_nettype wire

// ---- testbench/enc_link_properties.sv ----
// Link checks between the counting channel and the encoder base
`timescale 1ns/1ps
`default_nettype none
module enc_link_properties (
  input wire logic I_CLK, // Core clock
  input wire logic I_RST_N, // Sync reset, active low
  input wire logic serial_shift_clock, // Shift clock
  input wire logic sel_lo_drv, // Select low, driven
  input wire logic sel_hi_drv, // Select high, driven
  input wire logic sel_oe, // Select drive enable
  input wire logic enc_select_lo, // Select low, resolved
  input wire logic enc_select_hi, // Select high, resolved
  input wire logic data_out, // Base data
  input wire logic data_oe, // Base data enable
  input wire logic data, // Resolved data
  input wire logic supply_fault_return // Fault level
);
  default clocking dclk @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  // Every half period lasts far longer than the base's edge filter
  sequence low_half;
    !serial_shift_clock [*8];
  endsequence
  sequence high_half;
    serial_shift_clock [*8];
  endsequence

  sel_undriven_a: assert property (!sel_oe |-> !enc_select_lo && !enc_select_hi)
    else $error("released select lines not at zero");
  answer_low_a: assert property ($rose(data_oe) |-> !serial_shift_clock)
    else $error("base answered outside a low half");
  sel_hold_a: assert property (data_oe |-> $stable({sel_oe, sel_lo_drv, sel_hi_drv}))
    else $error("select moved during a frame");
  low_len_a: assert property ($fell(serial_shift_clock) |-> low_half)
    else $error("shift clock low half too short");
  high_len_a: assert property ($rose(serial_shift_clock) |-> high_half)
    else $error("shift clock high half too short");
  bit_in_low_a: assert property (data_oe && $past(data_oe) && $changed(data_out)
    |-> !serial_shift_clock)
    else $error("data bit changed while clock high");
  release_high_a: assert property ($fell(data_oe) |-> serial_shift_clock)
    else $error("data released before last rise");
  sel_idle_a: assert property ($changed({sel_oe, sel_lo_drv, sel_hi_drv})
    |-> serial_shift_clock && !data_oe)
    else $error("select changed while link busy");
endmodule
`default_nettype wire

// ---- testbench/absolute_encoder_mux_base_tb.sv ----
// Bench joining a counting channel to one encoder base over the link
`timescale 1ns/1ps
`default_nettype none
module absolute_encoder_mux_base_tb;
  typedef struct packed {
    logic [enc_mux_pkg::WORD_W-1:0] word;
    logic fault;
    logic inh_a;
    logic inh_b;
    logic busy;
  } exp_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [1:0] addr = 2'h0;
  logic drive = 1'b0;
  logic [2:0] rate_sel = 3'h0;
  logic [23:0] pins = 24'h0;
  logic two = 1'b0;
  logic [1:0] first = 2'h0;
  logic neg = 1'b0;
  logic act_high = 1'b1;
  logic [11:0] nominal = 12'h3e8;
  logic [11:0] sense = 12'h3e8;
  logic busy, valid, fault, inh_a, inh_b, base_busy;
  logic [23:0] word;
  logic [31:0] seed = 32'h51;
  int err_count = 0;
  int n_compared = 0;
  exp_t exp_q[$];

  always #2 clk = ~clk;

  enc_link_if enc_link_if_i ();
  counting_channel #(.ADDR_SETTLE_CYC(8)) counting_channel_i (
    .I_CLK(clk), .I_RST_N(rst_n), .link(enc_link_if_i.channel),
    .I_START(start), .I_ADDR(addr), .I_DRIVE_ADDR(drive),
    .I_RATE_SEL(rate_sel), .O_BUSY(busy), .O_WORD_VALID(valid),
    .O_WORD(word), .O_SUPPLY_FAULT(fault));
  encoder_base encoder_base_i (
    .I_CLK(clk), .I_RST_N(rst_n), .link(enc_link_if_i.base),
    .I_PARALLEL_WORD_INPUTS(pins), .I_TWO_ENCODERS(two),
    .I_FIRST_ADDR(first), .I_NEG_LOGIC(neg),
    .I_INHIBIT_ACT_HIGH(act_high), .I_SUPPLY_NOMINAL(nominal),
    .I_SUPPLY_SENSE(sense), .O_INHIBIT_ENCODER_A(inh_a),
    .O_INHIBIT_ENCODER_B(inh_b), .O_BUSY(base_busy));
  enc_link_properties enc_link_properties_i (
    .I_CLK(clk), .I_RST_N(rst_n),
    .serial_shift_clock(enc_link_if_i.serial_shift_clock),
    .sel_lo_drv(enc_link_if_i.sel_lo_drv),
    .sel_hi_drv(enc_link_if_i.sel_hi_drv), .sel_oe(enc_link_if_i.sel_oe),
    .enc_select_lo(enc_link_if_i.enc_select_lo),
    .enc_select_hi(enc_link_if_i.enc_select_hi),
    .data_out(enc_link_if_i.data_out), .data_oe(enc_link_if_i.data_oe),
    .data(enc_link_if_i.data),
    .supply_fault_return(enc_link_if_i.supply_fault_return));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic finish_test();
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check_word(input logic [23:0] exp);
    n_compared++;
    if (word !== exp) begin
      err_count++;
      $display("FAIL %0t word %h expected %h", $time, word, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // One read: settle the configuration, note the outcome, then start
  task automatic frame(input logic [1:0] a, input logic drv,
    input logic tw, input logic [1:0] fa, input logic ng,
    input logic ah, input logic [11:0] sn);
    exp_t e;
    logic [23:0] w;
    logic [1:0] ea;
    logic own_a;
    logic own_b;
    int i;
    seed = xs(seed);
    w = seed[23:0];
    ea = drv ? a : 2'h0;
    own_a = (ea == fa);
    own_b = tw && fa != 2'h3 && ea == fa + 2'h1;
    e.word = (own_a || own_b) ? (ng ? ~w : w) : 24'hffffff;
    e.fault = !tw && (int'(sn) * 100 < int'(nominal) * 85);
    e.inh_a = own_a ? ~ah : ah;
    e.inh_b = own_b ? ~ah : ah;
    e.busy = own_a || own_b;
    @(posedge clk);
    two <= tw;
    first <= fa;
    neg <= ng;
    act_high <= ah;
    sense <= sn;
    pins <= w;
    addr <= a;
    drive <= drv;
    repeat (8) @(posedge clk);
    exp_q.push_back(e);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (2000) @(posedge clk);
    seed = xs(seed);
    // Pins move mid-frame; the captured word must not
    pins <= seed[23:0];
    for (i = 0; i < 20000 && busy !== 1'b0; i++) begin
      @(posedge clk);
    end
  endtask

  always @(negedge clk) begin
    exp_t got;
    if (valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("FAIL %0t word without a pending read", $time);
      end else begin
        got = exp_q.pop_front();
        check_word(got.word);
        check_flag(fault, got.fault);
        check_flag(inh_a, got.inh_a);
        check_flag(inh_b, got.inh_b);
        check_flag(base_busy, got.busy);
      end
    end
  end

  initial begin
    #400000;
    err_count++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    frame(2'h2, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1, 12'h3e8);
    frame(2'h1, 1'b1, 1'b1, 2'h0, 1'b0, 1'b1, 12'h320);
    frame(2'h3, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0, 12'h3e8);
    frame(2'h3, 1'b1, 1'b1, 2'h2, 1'b0, 1'b1, 12'h3e8);
    // Second reset between frames
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    frame(2'h2, 1'b1, 1'b1, 2'h2, 1'b0, 1'b1, 12'h3e8);
    frame(2'h2, 1'b1, 1'b0, 2'h2, 1'b0, 1'b1, 12'h320);
    frame(2'h1, 1'b1, 1'b0, 2'h1, 1'b1, 1'b1, 12'h35c);
    rate_sel <= 3'h1;
    frame(2'h0, 1'b1, 1'b0, 2'h0, 1'b0, 1'b1, 12'h351);
    repeat (10) @(posedge clk);
    if (exp_q.size() != 0) begin
      err_count++;
      $display("FAIL %0t reads never answered", $time);
    end
    finish_test();
  end
endmodule
`default_nettype wire
